/* rtl/tdl_regs.svh */
// Constants of the tamper detect logger
`ifndef TDL_REGS_SVH
`define TDL_REGS_SVH
`define TDL_NUM_INPUTS 4
`define TDL_LOG_DEPTH 4
`define TDL_TIME_W 32
`define TDL_FLAG_W 5
`define TDL_FLAG_OSC 4
`define TDL_FILT_SHORT 12'h002
`define TDL_FILT_LONG 12'hBFF
`define TDL_CNT_W 12
`define TDL_MEM_ALL 2'h0
`define TDL_MEM_HIGH 2'h1
`define TDL_MEM_LOW 2'h2
`define TDL_MEM_NONE 2'h3
`define TDL_WR_BUSY 2'h2
`endif

/* rtl/tdl_pkg.sv */
// Types of the tamper detect logger
package tdl_pkg;
  typedef enum logic [1:0] {
    TDL_MEM_ALL_E = 2'h0,
    TDL_MEM_HIGH_E = 2'h1,
    TDL_MEM_LOW_E = 2'h2,
    TDL_MEM_NONE_E = 2'h3
  } tdl_mem_t;
  typedef struct packed {
    logic [11:0] cnt;
    logic hit;
  } tdl_filt_t;
endpackage : tdl_pkg

/* rtl/tdl_filter.sv */
// Input qualifier: polarity, enable and hold-time filter for one pin
`include "tdl_regs.svh"
`timescale 1ns/1ps
module tdl_filter (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Configuration
  input wire logic enable_i,
  input wire logic active_high_i,
  input wire logic long_i,
  // Pin and result
  input wire logic pin_i,
  output logic event_o
);
  tdl_pkg::tdl_filt_t s_q, s_d;
  logic active;
  logic [11:0] need;
  always_comb begin
    s_d = s_q;
    active = enable_i & (pin_i == active_high_i);
    need = long_i ? `TDL_FILT_LONG : `TDL_FILT_SHORT;
    s_d.hit = 1'b0;
    if (!active) begin
      s_d.cnt = '0;
    end else if (s_q.cnt != need) begin
      s_d.cnt = s_q.cnt + 12'h001;
      s_d.hit = ((s_q.cnt + 12'h001) == need);
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign event_o = s_q.hit;
endmodule : tdl_filter

/* rtl/tdl_top.sv */
// Tamper detect logger top: inputs, log, responses and lock
// Function
// - Clear command resets event flag and log
// - Locked registers refuse control writes
// - Write-complete status; software waits for it
// - Event applies configured RAM erase response
// - Option selects wake on tamper event
// - Four log entries read by index
// - Entry holds capture time and source flags
// - Logged time is the seconds counter
// - Flags: inputs 0 to 3 and oscillator
// - Reads leave entries intact until clear
// - Log only while a free entry exists
// - Report external oscillator running, as a registered copy of its input
// - Each input has its own enable
// - Short filter needs two cycles held
// - Long filter needs 3071 cycles held
// - Per-input weak pull-up control bit
// - Per-input polarity selects active level
// - Tamper settings override general-purpose pin use
// - Event during clear is kept, logged after
`include "tdl_regs.svh"
`timescale 1ns/1ps
module tdl_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control write port
  input wire logic ctl_wr_i,
  input wire logic tamper_en_i,
  input wire logic [1:0] mem_resp_i,
  input wire logic event_wakes_system_i,
  input wire logic [3:0] input_en_i,
  input wire logic [3:0] input_pullup_on_i,
  input wire logic [3:0] active_high_i,
  input wire logic [3:0] long_filter_i,
  input wire logic clear_all_events_i,
  input wire logic oscillator_recovery_i,
  input wire logic unlock_i,
  input wire logic control_lock_i,
  // Pins and environment
  input wire logic [3:0] tamper_pin_i,
  input wire logic [3:0] gpio_pullup_i,
  input wire logic osc_running_i,
  input wire logic osc_selected_i,
  input wire logic [31:0] seconds_i,
  input wire logic hibernating_i,
  // Log read
  input wire logic [1:0] log_index_i,
  output logic [31:0] log_time_o,
  output logic [4:0] log_flags_o,
  output logic log_valid_o,
  // Status
  output logic write_done_o,
  output logic locked_o,
  output logic tamper_active_o,
  output logic event_seen_o,
  output logic osc_valid_o,
  output logic osc_failed_o,
  output logic log_full_o,
  // Responses
  output logic [3:0] pullup_en_o,
  output logic [3:0] pin_owned_o,
  output logic erase_req_o,
  output logic [1:0] erase_sel_o,
  output logic wake_o,
  output logic nmi_o
);
  typedef struct packed {
    logic tamper_en;
    logic [1:0] mem_resp;
    logic wake_en;
    logic [3:0] in_en;
    logic [3:0] pull;
    logic [3:0] hi;
    logic [3:0] lng;
    logic locked;
    logic [1:0] wr_cnt;
    logic clearing;
    logic [4:0] pend;
    logic event_seen;
    logic osc_ok;
    logic osc_failed;
    logic [3:0] valid;
    logic [31:0] rd_time;
    logic [4:0] rd_flags;
    logic rd_valid;
    logic [3:0] pull_o;
    logic [3:0] own_o;
    logic erase;
    logic [1:0] erase_sel;
    logic wake;
    logic nmi;
  } tdl_state_t;
  tdl_state_t s_q, s_d;
  logic [31:0] log_time_q [`TDL_LOG_DEPTH];
  logic [4:0] log_flags_q [`TDL_LOG_DEPTH];
  logic [3:0] hit;
  logic [4:0] src;
  logic wr_any;
  logic write_ok;
  logic do_log;
  logic [1:0] slot;
  function automatic logic [1:0] first_free(input logic [3:0] v);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (!v[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction : first_free
  for (genvar g = 0; g < `TDL_NUM_INPUTS; g++) begin : g_in
    tdl_filter u_filt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .enable_i(s_q.tamper_en & s_q.in_en[g]),
      .active_high_i(s_q.hi[g]),
      .long_i(s_q.lng[g]),
      .pin_i(tamper_pin_i[g]),
      .event_o(hit[g])
    );
  end
  always_comb begin
    s_d = s_q;
    wr_any = ctl_wr_i | clear_all_events_i | oscillator_recovery_i;
    // Busy writes are dropped; software must poll write_done_o first
    write_ok = (s_q.wr_cnt == 2'h0);
    if (write_ok && (wr_any || unlock_i || control_lock_i)) begin
      s_d.wr_cnt = `TDL_WR_BUSY;
    end else if (s_q.wr_cnt != 2'h0) begin
      s_d.wr_cnt = s_q.wr_cnt - 2'h1;
    end
    if (write_ok && unlock_i) begin
      s_d.locked = 1'b0;
    end
    if (write_ok && control_lock_i) begin
      s_d.locked = 1'b1;
    end
    if (write_ok && ctl_wr_i && !s_q.locked) begin
      s_d.tamper_en = tamper_en_i;
      s_d.mem_resp = mem_resp_i;
      s_d.wake_en = event_wakes_system_i;
      s_d.in_en = input_en_i;
      s_d.pull = input_pullup_on_i;
      s_d.hi = active_high_i;
      s_d.lng = long_filter_i;
    end
    // Oscillator watch: a drop while valid and tamper enabled is a failure event
    s_d.osc_ok = osc_running_i;
    src = {s_q.tamper_en & s_q.osc_ok & ~osc_running_i, hit};
    if (write_ok && oscillator_recovery_i && !s_q.locked
        && osc_selected_i && osc_running_i) begin
      s_d.osc_failed = 1'b0;
    end
    if (src[`TDL_FLAG_OSC]) begin
      s_d.osc_failed = 1'b1;
    end
    s_d.clearing = 1'b0;
    if (write_ok && clear_all_events_i && !s_q.locked) begin
      s_d.clearing = 1'b1;
    end
    // Events arriving during a clear are parked and logged after it
    s_d.pend = s_q.clearing ? (s_q.pend | src) : 5'h00;
    if (s_q.clearing) begin
      s_d.event_seen = 1'b0;
      s_d.valid = 4'h0;
    end
    do_log = !s_q.clearing && ((src | s_q.pend) != 5'h00);
    slot = first_free(s_q.valid);
    if (do_log) begin
      s_d.event_seen = 1'b1;
      if (s_q.valid != 4'hF) begin
        s_d.valid[slot] = 1'b1;
      end
    end
    s_d.erase = do_log && (s_q.mem_resp != `TDL_MEM_NONE);
    s_d.erase_sel = s_q.mem_resp;
    s_d.wake = do_log && s_q.wake_en && hibernating_i;
    s_d.nmi = s_d.event_seen;
    s_d.rd_time = log_time_q[log_index_i];
    s_d.rd_flags = log_flags_q[log_index_i];
    s_d.rd_valid = s_q.valid[log_index_i];
    s_d.pull_o = s_q.pull & s_q.in_en & {4{s_q.tamper_en}};
    s_d.own_o = s_q.in_en & {4{s_q.tamper_en}};
    s_d.pull_o = s_d.pull_o | (gpio_pullup_i & ~s_d.own_o);
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.mem_resp <= `TDL_MEM_NONE;
      s_q.locked <= 1'b1;
      s_q.erase_sel <= `TDL_MEM_NONE;
    end else begin
      s_q <= s_d;
    end
  end
  always_ff @(posedge clk_i) begin
    if (do_log && s_q.valid != 4'hF) begin
      log_time_q[slot] <= seconds_i;
      log_flags_q[slot] <= src | s_q.pend;
    end
  end
  assign log_time_o = s_q.rd_time;
  assign log_flags_o = s_q.rd_flags;
  assign log_valid_o = s_q.rd_valid;
  assign write_done_o = (s_q.wr_cnt == 2'h0);
  assign locked_o = s_q.locked;
  assign tamper_active_o = s_q.tamper_en;
  assign event_seen_o = s_q.event_seen;
  assign osc_valid_o = s_q.osc_ok;
  assign osc_failed_o = s_q.osc_failed;
  assign log_full_o = &s_q.valid;
  assign pullup_en_o = s_q.pull_o;
  assign pin_owned_o = s_q.own_o;
  assign erase_req_o = s_q.erase;
  assign erase_sel_o = s_q.erase_sel;
  assign wake_o = s_q.wake;
  assign nmi_o = s_q.nmi;
endmodule : tdl_top

/* testbench/tdl_properties.sv */
// Port checker of the tamper detect logger top
`timescale 1ns/1ps
module tdl_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Requests
  input wire logic ctl_wr_i,
  input wire logic clear_all_events_i,
  input wire logic [1:0] log_index_i,
  // Status and responses
  input wire logic write_done_o,
  input wire logic locked_o,
  input wire logic event_seen_o,
  input wire logic log_valid_o,
  input wire logic log_full_o,
  input wire logic erase_req_o,
  input wire logic wake_o,
  input wire logic nmi_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_clear;
    clear_all_events_i && write_done_o && !locked_o |-> ##2 !event_seen_o;
  endproperty
  a_clear: assert property (p_clear) else $error("flag kept after clear");
  property p_refuse;
    locked_o && write_done_o && clear_all_events_i && event_seen_o
      |-> ##2 event_seen_o;
  endproperty
  a_refuse: assert property (p_refuse) else $error("locked clear acted");
  property p_busy;
    (ctl_wr_i || clear_all_events_i) && write_done_o
      |=> !write_done_o ##2 write_done_o;
  endproperty
  a_busy: assert property (p_busy) else $error("write status wrong");
  property p_nmi;
    nmi_o == event_seen_o;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi differs from flag");
  property p_erase;
    erase_req_o |-> event_seen_o;
  endproperty
  a_erase: assert property (p_erase) else $error("erase without event");
  property p_wake;
    wake_o |-> event_seen_o;
  endproperty
  a_wake: assert property (p_wake) else $error("wake without event");
  property p_full;
    log_full_o && !clear_all_events_i && !$past(clear_all_events_i)
      |=> log_full_o;
  endproperty
  a_full: assert property (p_full) else $error("full log emptied");
  property p_keep;
    log_valid_o && $stable(log_index_i) && !clear_all_events_i &&
      !$past(clear_all_events_i) && !$past(clear_all_events_i, 2)
      |=> log_valid_o;
  endproperty
  a_keep: assert property (p_keep) else $error("entry lost on read");
endmodule : tdl_checker

bind tdl_top tdl_checker chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .ctl_wr_i(ctl_wr_i),
  .clear_all_events_i(clear_all_events_i), .log_index_i(log_index_i),
  .write_done_o(write_done_o), .locked_o(locked_o),
  .event_seen_o(event_seen_o), .log_valid_o(log_valid_o),
  .log_full_o(log_full_o), .erase_req_o(erase_req_o), .wake_o(wake_o),
  .nmi_o(nmi_o)
);

/* testbench/tdl_switches.sv */
// Model of the tamper switches and the external oscillator
`timescale 1ns/1ps
module tdl_switches (
  // Clock
  input wire logic clk_i,
  // Bench commands and device pull-ups
  input wire logic [3:0] closed_i,
  input wire logic osc_stop_i,
  input wire logic [3:0] pullup_i,
  // Pins
  output logic [3:0] pin_o,
  output logic osc_o
);
  logic [3:0] float_q = 4'h0;
  // An open pin without pull-up wanders instead of keeping its level
  always @(posedge clk_i) float_q <= ~float_q;
  assign pin_o = ~closed_i & (pullup_i | float_q);
  assign osc_o = !osc_stop_i;
endmodule : tdl_switches

/* testbench/tdl_top_bench.sv */
// Self-checking bench of the tamper detect logger
`timescale 1ns/1ps
module tdl_top_bench;
  // Rows: mem, wake, enable, high polarity, pressed, event expected
  typedef struct packed {
    logic [1:0] mem;
    logic wake, en, hi, press, exp;
  } tdl_row_t;
  tdl_row_t rows [5] = '{7'h1B, 7'h2B, 7'h6B, 7'h12, 7'h5D};
  logic clk_i = 1'h0, rst_i = 1'h1, tamper_en_i = 1'h0, osc_stop = 1'h0;
  logic event_wakes_system_i = 1'h0, osc_running_i;
  logic [4:0] st = 5'h00, log_flags_o;
  logic [1:0] mem_resp_i = 2'h0, log_index_i = 2'h0, erase_sel_o;
  logic [3:0] input_en_i = 4'h0, active_high_i = 4'h0, long_filter_i = 4'h0;
  logic [3:0] closed = 4'h0, gpio_pullup_i = 4'hF, tamper_pin_i;
  logic [3:0] pullup_en_o, pin_owned_o;
  logic [31:0] seconds_i = 32'h0, log_time_o;
  logic log_valid_o, write_done_o, locked_o, tamper_active_o, event_seen_o;
  logic osc_valid_o, osc_failed_o, log_full_o, erase_req_o, wake_o, nmi_o;
  int miscompares = 0, checks = 0;
  always #5 clk_i = ~clk_i;
  tdl_top dut_u (.clk_i, .rst_i, .ctl_wr_i(st[0]),
    .clear_all_events_i(st[1]), .oscillator_recovery_i(st[2]),
    .unlock_i(st[3]), .control_lock_i(st[4]), .tamper_en_i, .mem_resp_i,
    .event_wakes_system_i, .input_en_i, .input_pullup_on_i(4'hF),
    .active_high_i, .long_filter_i, .tamper_pin_i, .gpio_pullup_i,
    .osc_running_i, .osc_selected_i(1'h1), .seconds_i,
    .hibernating_i(1'h1), .log_index_i, .log_time_o, .log_flags_o,
    .log_valid_o, .write_done_o, .locked_o, .tamper_active_o, .event_seen_o,
    .osc_valid_o, .osc_failed_o, .log_full_o, .pullup_en_o, .pin_owned_o,
    .erase_req_o, .erase_sel_o, .wake_o, .nmi_o);
  tdl_switches sw_u (.clk_i, .closed_i(closed), .osc_stop_i(osc_stop),
    .pullup_i(pullup_en_o), .pin_o(tamper_pin_i), .osc_o(osc_running_i));
  task chk(input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch at %0t: saw %0h want %0h", $time, s, e);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  // One strobe per write, then wait out the busy window
  task pulse(input int k);
    @(posedge clk_i) st <= 5'h01 << k;
    @(posedge clk_i) st <= 5'h00;
    tick(4);
  endtask : pulse
  task wait_ev(input int n);
    for (int k = 0; k < n; k++) begin
      tick(1);
      if (event_seen_o === 1'h1) break;
    end
  endtask : wait_ev
  task end_sim;
    if (miscompares == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim
  initial begin
    #200000;
    miscompares++;
    end_sim();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
    tick(1);
    chk(locked_o, 1);
    chk(write_done_o, 1);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_i) closed <= {3'h0, rows[i].hi};
      seconds_i <= 32'h100 + i;
      pulse(3);
      // Settings go in with the enable so detection starts configured
      @(posedge clk_i) tamper_en_i <= 1'h1;
      mem_resp_i <= rows[i].mem;
      event_wakes_system_i <= rows[i].wake;
      input_en_i <= {3'h0, rows[i].en};
      active_high_i <= {3'h0, rows[i].hi};
      pulse(0);
      @(posedge clk_i) closed <= {3'h0, rows[i].press};
      wait_ev(10);
      chk(event_seen_o, rows[i].exp);
      if (rows[i].exp) begin
        chk(erase_sel_o, rows[i].mem);
        chk(wake_o, rows[i].wake);
        tick(2);
        chk(log_time_o, 32'h100 + i);
        chk(log_flags_o, 5'h01);
      end
      @(posedge clk_i) closed <= {3'h0, rows[i].hi};
      pulse(3);
      pulse(1);
      pulse(4);
      chk(event_seen_o, 0);
    end
    // Pin 0 is held closed, so the new polarity logs it at once
    pulse(3);
    @(posedge clk_i) active_high_i <= 4'h0;
    input_en_i <= 4'hF;
    mem_resp_i <= 2'h3;
    gpio_pullup_i <= 4'h0;
    pulse(0);
    for (int k = 1; k < 5; k++) begin
      // One drive of the pins per edge: k 1-2 press, 3 oscillator, 4 pin 3
      @(posedge clk_i) closed <= (k == 4) ? 4'h8 :
        ((k > 2) ? 4'h0 : 4'h1 << k);
      osc_stop <= (k > 2);
      tick(8);
      if (k == 3) chk(osc_failed_o, 1);
      if (k == 3) chk(osc_valid_o, 0);
    end
    chk(pullup_en_o, 4'hF);
    chk(log_full_o, 1);
    for (int k = 0; k < 5; k++) begin
      @(posedge clk_i) log_index_i <= k[1:0];
      tick(2);
      chk(log_flags_o, (k == 3) ? 5'h10 : 5'h01 << k[1:0]);
    end
    @(posedge clk_i) osc_stop <= 1'h0;
    closed <= 4'h0;
    tick(4);
    chk(osc_valid_o, 1);
    pulse(2);
    chk(osc_failed_o, 0);
    pulse(4);
    pulse(1);
    chk(event_seen_o, 1);
    pulse(3);
    pulse(1);
    chk(log_valid_o, 0);
    @(posedge clk_i) input_en_i <= 4'h2;
    long_filter_i <= 4'h2;
    pulse(0);
    @(posedge clk_i) closed <= 4'h2;
    tick(3000);
    @(posedge clk_i) closed <= 4'h0;
    @(posedge clk_i) closed <= 4'h2;
    tick(3060);
    chk(event_seen_o, 0);
    wait_ev(30);
    chk(event_seen_o, 1);
    end_sim();
  end
endmodule : tdl_top_bench
